// ---- hdl/stm_pkg.sv ----
package stm_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 24;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned THR_W = 10;
    localparam int unsigned EDGE_W = 2;
    localparam int unsigned SIZE_W = 2;
    localparam int unsigned POLL_W = 3;
    localparam int unsigned CYC_W = 19;

    // Register offsets
    localparam logic [5:0] OFS_MAP_IN8_17 = 6'h2f;
    localparam logic [5:0] OFS_MAP_SENSE_UPPER = 6'h30;
    localparam logic [5:0] OFS_MATRIX_CFG = 6'h31;

    // Reset values
    localparam logic [23:0] RST_MAP_IN8_17 = 24'h000000;
    localparam logic [23:0] RST_MAP_SENSE_UPPER = 24'h000000;
    localparam logic [23:0] RST_MATRIX_CFG = 24'h000000;

    // Writable bit masks; everything else is reserved
    localparam logic [23:0] MASK_MAP_IN8_17 = 24'h03ffff;
    localparam logic [23:0] MASK_MAP_SENSE_UPPER = 24'h1fffff;
    localparam logic [23:0] MASK_MATRIX_CFG = 24'h01ffff;

    // Field positions, first mapping register
    localparam int unsigned POS_IN8 = 0;
    localparam int unsigned POS_IN9 = 3;
    localparam int unsigned POS_IN10 = 6;
    localparam int unsigned POS_IN11 = 9;
    localparam int unsigned POS_G12_A = 12;
    localparam int unsigned POS_G12_B = 15;

    // Field positions, second mapping register
    localparam int unsigned POS_G18_A = 0;
    localparam int unsigned POS_G18_B = 3;
    localparam int unsigned POS_G18_C = 6;
    localparam int unsigned POS_S0_A = 9;
    localparam int unsigned POS_S0_B = 12;
    localparam int unsigned POS_S1_A = 15;
    localparam int unsigned POS_S1_B = 18;

    // Field positions, matrix register
    localparam int unsigned POS_POLL = 0;
    localparam int unsigned POS_SIZE = 3;
    localparam int unsigned POS_THR = 5;
    localparam int unsigned POS_EDGE = 15;

    // Matrix sizes
    typedef enum logic [1:0]
    {
        STM_SIZE_NONE = 2'b00,
        STM_SIZE_4X4 = 2'b01,
        STM_SIZE_5X5 = 2'b10,
        STM_SIZE_6X6 = 2'b11
    } stm_size_e;

    // Interrupt edge selection on the shared matrix threshold
    typedef enum logic [1:0]
    {
        STM_EDGE_OFF = 2'b00,
        STM_EDGE_RISE = 2'b01,
        STM_EDGE_FALL = 2'b10,
        STM_EDGE_BOTH = 2'b11
    } stm_edge_e;

    // Polling active times in microseconds, by code
    localparam int unsigned POLL_US_0 = 64;
    localparam int unsigned POLL_US_1 = 128;
    localparam int unsigned POLL_US_2 = 256;
    localparam int unsigned POLL_US_3 = 384;
    localparam int unsigned POLL_US_4 = 512;
    localparam int unsigned POLL_US_5 = 768;
    localparam int unsigned POLL_US_6 = 1024;
    localparam int unsigned POLL_US_7 = 1360;

    // System clock rate, cycles per microsecond
    localparam int unsigned SYS_CLK_MHZ = 250;

endpackage

// ---- hdl/stm_cross_detect.sv ----
`timescale 1ns/1ns
// Flags crossings of the shared matrix threshold, filtered by the edge selection
module stm_cross_detect
    import stm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic [1:0] edge_sel,
    input wire logic [9:0] threshold,
    input wire logic sample_valid,
    input wire logic [9:0] sample_value,
    output logic cross_event
);

    logic above; // Last sample was above the threshold
    logic primed; // A reference sample exists
    logic next_above;
    logic next_primed;
    logic next_cross_event;
    logic now_above;
    logic rise;
    logic fall;

    // Compare and classify the new sample against the stored side
    always_comb
    begin
        now_above = sample_value > threshold;
        rise = primed && !above && now_above;
        fall = primed && above && !now_above;
        next_above = above;
        next_primed = primed;
        next_cross_event = 1'b0;
        if (!enable)
        begin
            // Forget history so a re-enable cannot fire on stale state
            next_primed = 1'b0;
        end
        else if (sample_valid)
        begin
            next_above = now_above;
            next_primed = 1'b1;
            case (edge_sel)
                STM_EDGE_OFF: next_cross_event = 1'b0;
                STM_EDGE_RISE: next_cross_event = rise;
                STM_EDGE_FALL: next_cross_event = fall;
                STM_EDGE_BOTH: next_cross_event = rise || fall;
                default: next_cross_event = 1'b0;
            endcase
        end
    end

    // Register the detector state
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            above <= 1'b0;
            primed <= 1'b0;
            cross_event <= 1'b0;
        end
        else
        begin
            above <= next_above;
            primed <= next_primed;
            cross_event <= next_cross_event;
        end
    end

    AST_EDGE_OFF_SILENT: assert property (@(posedge sys_clk) disable iff (!rstn)
        $past(edge_sel) == STM_EDGE_OFF |-> !cross_event)
        else $error("Event raised with edge selection off");

    AST_RISE_ONLY: assert property (@(posedge sys_clk) disable iff (!rstn)
        cross_event && $past(edge_sel) == STM_EDGE_RISE |-> $past(now_above))
        else $error("Rising-only mode flagged a falling crossing");

endmodule

// ---- hdl/stm_threshold_map_cfg.sv ----
`timescale 1ns/1ns
module stm_threshold_map_cfg
    import stm_pkg::*;
#(
    parameter int unsigned POLL_CYC_PER_US = SYS_CLK_MHZ
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic reg_rdata_hit,
    output logic [2:0] input8_threshold_select,
    output logic [2:0] input9_threshold_select,
    output logic [2:0] input10_threshold_select,
    output logic [2:0] input11_threshold_select,
    output logic [2:0] group12_17_select_a,
    output logic [2:0] group12_17_select_b,
    output logic [2:0] group18_23_select_a,
    output logic [2:0] group18_23_select_b,
    output logic [2:0] group18_23_select_c,
    output logic [2:0] sense_group0_select_a,
    output logic [2:0] sense_group0_select_b,
    output logic [2:0] sense_group1_select_a,
    output logic [2:0] sense_group1_select_b,
    output logic [9:0] shared_matrix_threshold,
    output logic [1:0] shared_threshold_irq_edge,
    output logic [1:0] matrix_size,
    output logic matrix_enabled,
    output logic [2:0] grid_poll_active_time,
    output logic [18:0] grid_poll_active_cycles,
    input wire logic grid_sample_valid,
    input wire logic [9:0] grid_sample_value,
    output logic shared_threshold_event
);

    // Microseconds for a poll code
    function automatic int unsigned poll_us(input logic [2:0] code);
        case (code)
            3'h0: poll_us = POLL_US_0;
            3'h1: poll_us = POLL_US_1;
            3'h2: poll_us = POLL_US_2;
            3'h3: poll_us = POLL_US_3;
            3'h4: poll_us = POLL_US_4;
            3'h5: poll_us = POLL_US_5;
            3'h6: poll_us = POLL_US_6;
            3'h7: poll_us = POLL_US_7;
            default: poll_us = POLL_US_0;
        endcase
    endfunction

    // Cycles of sys_clk for a poll code
    function automatic logic [18:0] poll_cycles(input logic [2:0] code);
        int unsigned cyc;
        cyc = poll_us(code) * POLL_CYC_PER_US;
        poll_cycles = cyc[18:0];
    endfunction

    // Write merge that keeps reserved positions at zero
    function automatic logic [23:0] masked(input logic [23:0] data, input logic [23:0] mask);
        masked = data & mask;
    endfunction

    logic [23:0] map_in8_17; // First mapping register contents
    logic [23:0] map_sense_upper; // Second mapping register contents
    logic [23:0] matrix_cfg; // Matrix register contents
    logic [23:0] next_map_in8_17;
    logic [23:0] next_map_sense_upper;
    logic [23:0] next_matrix_cfg;
    logic [23:0] next_reg_rdata;
    logic next_reg_rdata_valid;
    logic next_reg_rdata_hit;
    logic [18:0] next_grid_poll_active_cycles;

    // Write decode: only writable bits are stored, a stray address is dropped
    always_comb
    begin
        next_map_in8_17 = map_in8_17;
        next_map_sense_upper = map_sense_upper;
        next_matrix_cfg = matrix_cfg;
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_MAP_IN8_17: next_map_in8_17 = masked(reg_wdata, MASK_MAP_IN8_17);
                OFS_MAP_SENSE_UPPER:
                    next_map_sense_upper = masked(reg_wdata, MASK_MAP_SENSE_UPPER);
                OFS_MATRIX_CFG: next_matrix_cfg = masked(reg_wdata, MASK_MATRIX_CFG);
                default:
                begin
                    // Unmapped offsets belong to other banks; nothing changes here
                end
            endcase
        end
    end

    // Configuration storage, cleared to slot zero and no matrix at reset
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            map_in8_17 <= RST_MAP_IN8_17;
            map_sense_upper <= RST_MAP_SENSE_UPPER;
            matrix_cfg <= RST_MATRIX_CFG;
        end
        else
        begin
            map_in8_17 <= next_map_in8_17;
            map_sense_upper <= next_map_sense_upper;
            matrix_cfg <= next_matrix_cfg;
        end
    end

    // Read decode; reads see the value before a same-cycle write
    always_comb
    begin
        next_reg_rdata = 24'h000000;
        next_reg_rdata_hit = 1'b0;
        next_reg_rdata_valid = reg_rd;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_MAP_IN8_17:
                begin
                    next_reg_rdata = masked(map_in8_17, MASK_MAP_IN8_17);
                    next_reg_rdata_hit = 1'b1;
                end
                OFS_MAP_SENSE_UPPER:
                begin
                    next_reg_rdata = masked(map_sense_upper, MASK_MAP_SENSE_UPPER);
                    next_reg_rdata_hit = 1'b1;
                end
                OFS_MATRIX_CFG:
                begin
                    next_reg_rdata = masked(matrix_cfg, MASK_MATRIX_CFG);
                    next_reg_rdata_hit = 1'b1;
                end
                default:
                begin
                    // Not ours: answer zero so the serial shifter sees a defined word
                    next_reg_rdata = 24'h000000;
                end
            endcase
        end
    end

    // Poll time in cycles, registered so downstream timers see a clean value
    always_comb
    begin
        next_grid_poll_active_cycles = poll_cycles(next_matrix_cfg[POS_POLL +: POLL_W]);
    end

    // Read port and derived timing registers
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            reg_rdata <= 24'h000000;
            reg_rdata_valid <= 1'b0;
            reg_rdata_hit <= 1'b0;
            grid_poll_active_cycles <= poll_cycles(3'h0);
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
            reg_rdata_valid <= next_reg_rdata_valid;
            reg_rdata_hit <= next_reg_rdata_hit;
            grid_poll_active_cycles <= next_grid_poll_active_cycles;
        end
    end

    // Selector fields; the code is the slot number of a separately held value
    assign input8_threshold_select = map_in8_17[POS_IN8 +: SEL_W];
    assign input9_threshold_select = map_in8_17[POS_IN9 +: SEL_W];
    assign input10_threshold_select = map_in8_17[POS_IN10 +: SEL_W];
    assign input11_threshold_select = map_in8_17[POS_IN11 +: SEL_W];
    assign group12_17_select_a = map_in8_17[POS_G12_A +: SEL_W];
    assign group12_17_select_b = map_in8_17[POS_G12_B +: SEL_W];
    assign group18_23_select_a = map_sense_upper[POS_G18_A +: SEL_W];
    assign group18_23_select_b = map_sense_upper[POS_G18_B +: SEL_W];
    assign group18_23_select_c = map_sense_upper[POS_G18_C +: SEL_W];
    assign sense_group0_select_a = map_sense_upper[POS_S0_A +: SEL_W];
    assign sense_group0_select_b = map_sense_upper[POS_S0_B +: SEL_W];
    assign sense_group1_select_a = map_sense_upper[POS_S1_A +: SEL_W];
    assign sense_group1_select_b = map_sense_upper[POS_S1_B +: SEL_W];

    // Matrix fields; threshold LSB sits at the low end of its field
    assign shared_matrix_threshold = matrix_cfg[POS_THR +: THR_W];
    assign shared_threshold_irq_edge = matrix_cfg[POS_EDGE +: EDGE_W];
    assign matrix_size = matrix_cfg[POS_SIZE +: SIZE_W];
    assign matrix_enabled = matrix_cfg[POS_SIZE +: SIZE_W] != STM_SIZE_NONE;
    assign grid_poll_active_time = matrix_cfg[POS_POLL +: POLL_W];

    // Crossing events only mean something while a matrix is wired up
    stm_cross_detect u_cross
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .enable(matrix_enabled),
        .edge_sel(shared_threshold_irq_edge),
        .threshold(shared_matrix_threshold),
        .sample_valid(grid_sample_valid),
        .sample_value(grid_sample_value),
        .cross_event(shared_threshold_event)
    );

    AST_MAP1_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MAP_IN8_17 |=> reg_rdata[23:18] == 6'h00)
        else $error("Reserved bits of first mapping register read nonzero");

    AST_MAP2_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MAP_SENSE_UPPER |=> reg_rdata[23:21] == 3'h0)
        else $error("Reserved bits of second mapping register read nonzero");

    AST_MATRIX_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MATRIX_CFG |=> reg_rdata[23:17] == 7'h00)
        else $error("Reserved bits of matrix register read nonzero");

    AST_WRITE_THR_LANDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == OFS_MATRIX_CFG
        |=> shared_matrix_threshold == $past(reg_wdata[14:5]))
        else $error("Matrix threshold did not take the written bits 14-5");

    AST_WRITE_G12B_LANDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == OFS_MAP_IN8_17
        |=> group12_17_select_b == $past(reg_wdata[17:15])
            && input11_threshold_select == $past(reg_wdata[11:9]))
        else $error("Selector did not take its written field");

    AST_S1B_LANDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == OFS_MAP_SENSE_UPPER
        |=> sense_group1_select_b == $past(reg_wdata[20:18])
            && group18_23_select_c == $past(reg_wdata[8:6]))
        else $error("Sense or upper group selector misplaced");

    AST_RESET_SLOT_ZERO: assert property (@(posedge sys_clk)
        !rstn |=> input8_threshold_select == 3'h0 && sense_group0_select_a == 3'h0
            && matrix_size == 2'h0)
        else $error("Selector not at slot zero after reset");

    AST_POLL_TIME_MAX: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == OFS_MATRIX_CFG && reg_wdata[2:0] == 3'h7
        |=> grid_poll_active_cycles == 19'(POLL_US_7 * POLL_CYC_PER_US))
        else $error("Poll time code 7 gave wrong cycle count");

    AST_NO_MATRIX_NO_EVENT: assert property (@(posedge sys_clk) disable iff (!rstn)
        !matrix_enabled [*2] |-> !shared_threshold_event)
        else $error("Crossing event with no matrix configured");

    AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr != OFS_MAP_IN8_17 && reg_addr != OFS_MAP_SENSE_UPPER
            && reg_addr != OFS_MATRIX_CFG |=> reg_rdata == 24'h000000 && !reg_rdata_hit)
        else $error("Unmapped read returned data");

    // Read-back mirrors: a field decoded from the wrong bits shows up here even when
    // every write lands, because reads and field outputs share one stored word
    AST_MAP1_READBACK: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MAP_IN8_17
        |=> reg_rdata_hit && reg_rdata[17:0] == $past({group12_17_select_b,
            group12_17_select_a, input11_threshold_select, input10_threshold_select,
            input9_threshold_select, input8_threshold_select}))
        else $error("First mapping register read does not mirror its selectors");

    AST_MAP2_READBACK: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MAP_SENSE_UPPER
        |=> reg_rdata_hit && reg_rdata[20:0] == $past({sense_group1_select_b,
            sense_group1_select_a, sense_group0_select_b, sense_group0_select_a,
            group18_23_select_c, group18_23_select_b, group18_23_select_a}))
        else $error("Second mapping register read does not mirror its selectors");

    AST_MATRIX_READBACK: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == OFS_MATRIX_CFG
        |=> reg_rdata_hit && reg_rdata[16:0] == $past({shared_threshold_irq_edge,
            shared_matrix_threshold, matrix_size, grid_poll_active_time}))
        else $error("Matrix register read does not mirror its fields");

    // A stray offset belongs to another bank, so none of ours may move
    AST_STRAY_WR_DROP: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr != OFS_MAP_IN8_17 && reg_addr != OFS_MAP_SENSE_UPPER
            && reg_addr != OFS_MATRIX_CFG
        |=> $stable(map_in8_17) && $stable(map_sense_upper) && $stable(matrix_cfg))
        else $error("Write to an unmapped offset changed this bank");

    // Selectors only move on a write to their own offset, so slot zero stays put
    AST_MAP1_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(reg_wr && reg_addr == OFS_MAP_IN8_17) |=> $stable(map_in8_17))
        else $error("First mapping register changed without a write");

    AST_MAP2_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(reg_wr && reg_addr == OFS_MAP_SENSE_UPPER) |=> $stable(map_sense_upper))
        else $error("Second mapping register changed without a write");

endmodule

// ---- bench/stm_host_model.sv ----
`timescale 1ns/1ns
// Host side of the register port: one whole-word access at a time
module stm_host_model
    import stm_pkg::*;
(
    input wire logic sys_clk,
    output logic [5:0] reg_addr,
    output logic [23:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [23:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic reg_rdata_hit
);
    // Quiet bus at time zero
    initial
    begin
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Write strobe for one edge; idle bus then shows the inverse so stale data cannot match
    task automatic write_word(input logic [5:0] addr, input logic [23:0] data);
        @(posedge sys_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    // Read strobe for one edge; answer pulse awaited for a bounded number of cycles
    task automatic read_word(input logic [5:0] addr, output logic [23:0] data,
        output logic hit, output logic ok);
        int n;
        @(posedge sys_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        ok = 1'b0;
        data = 24'h000000;
        hit = 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (reg_rdata_valid === 1'b1)
            begin
                ok = 1'b1;
                data = reg_rdata;
                hit = reg_rdata_hit;
            end
            else
                @(posedge sys_clk);
        end
    endtask
endmodule

// ---- bench/switch_threshold_map_matrix_cfg_bench.sv ----
`timescale 1ns/1ns
// Self-checking bench for the threshold map and matrix configuration bank
module switch_threshold_map_matrix_cfg_bench
    import stm_pkg::*;
;
    // Short microsecond so poll counts stay small
    localparam int unsigned CYC_US = 2;
    logic sys_clk;
    logic rstn;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rdata_valid, reg_rdata_hit;
    logic [2:0] in8, in9, in10, in11, g12a, g12b, g18a, g18b, g18c, s0a, s0b, s1a, s1b;
    logic [9:0] thr;
    logic [1:0] edge_sel, msize;
    logic menab;
    logic [2:0] poll;
    logic [18:0] poll_cyc;
    logic smp_valid;
    logic [9:0] smp_value;
    logic cross_evt;
    int bad_count = 0;
    int total_checks = 0;
    int unsigned poll_us [8] = '{POLL_US_0, POLL_US_1, POLL_US_2, POLL_US_3,
        POLL_US_4, POLL_US_5, POLL_US_6, POLL_US_7};
    // Field outputs packed in register order, so one compare proves every position
    wire [17:0] map1_seen = {g12b, g12a, in11, in10, in9, in8};
    wire [20:0] map2_seen = {s1b, s1a, s0b, s0a, g18c, g18b, g18a};
    wire [16:0] mat_seen = {edge_sel, thr, msize, poll};

    stm_threshold_map_cfg #(.POLL_CYC_PER_US(CYC_US)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .reg_rdata_hit(reg_rdata_hit),
        .input8_threshold_select(in8), .input9_threshold_select(in9),
        .input10_threshold_select(in10), .input11_threshold_select(in11),
        .group12_17_select_a(g12a), .group12_17_select_b(g12b),
        .group18_23_select_a(g18a), .group18_23_select_b(g18b), .group18_23_select_c(g18c),
        .sense_group0_select_a(s0a), .sense_group0_select_b(s0b),
        .sense_group1_select_a(s1a), .sense_group1_select_b(s1b),
        .shared_matrix_threshold(thr), .shared_threshold_irq_edge(edge_sel),
        .matrix_size(msize), .matrix_enabled(menab), .grid_poll_active_time(poll),
        .grid_poll_active_cycles(poll_cyc), .grid_sample_valid(smp_valid),
        .grid_sample_value(smp_value), .shared_threshold_event(cross_evt));

    stm_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .reg_rdata_hit(reg_rdata_hit));

    // Free-running 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    // Verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Read a register and compare data and hit flag; a lost answer ends the run
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp, input logic exp_hit);
        logic [23:0] d;
        logic h, ok;
        host.read_word(a, d, h, ok);
        if (!ok)
        begin
            bad_count++;
            $display("MISMATCH at %0t: no read answer", $time);
            conclude();
        end
        else
        begin
            check(d, exp);
            check({23'h0, h}, {23'h0, exp_hit});
        end
    endtask

    // One matrix sample; any event in the next three cycles counts
    task automatic send(input logic [9:0] v, output logic fired);
        @(posedge sys_clk);
        smp_valid <= 1'b1;
        smp_value <= v;
        @(posedge sys_clk);
        smp_valid <= 1'b0;
        smp_value <= ~v;
        fired = 1'b0;
        repeat (3)
        begin
            #1;
            fired = fired | (cross_evt === 1'b1);
            @(posedge sys_clk);
        end
    endtask

    // Everything reads zero out of reset
    task automatic t_reset();
        rd_chk(6'h2f, 24'h000000, 1'b1);
        rd_chk(6'h30, 24'h000000, 1'b1);
        rd_chk(6'h31, 24'h000000, 1'b1);
        check({6'h0, map1_seen}, 24'h000000);
        check({3'h0, map2_seen}, 24'h000000);
        check(24'(poll_cyc), 24'(POLL_US_0 * CYC_US));
    endtask

    // Every code in every selector, then a distinct code per field to catch swaps
    task automatic t_maps();
        logic [23:0] w1, w2;
        for (int p = 0; p < 9; p++)
        begin
            w2 = 24'h000000;
            for (int k = 0; k < 7; k++)
                w2[3*k +: 3] = (p < 8) ? 3'(p) : 3'(k + 1);
            w1 = {6'h0, w2[17:0]};
            host.write_word(6'h2f, w1 | 24'hfc0000);
            host.write_word(6'h30, w2 | 24'he00000);
            rd_chk(6'h2f, w1, 1'b1);
            rd_chk(6'h30, w2, 1'b1);
            check({6'h0, map1_seen}, w1);
            check({3'h0, map2_seen}, w2);
        end
    endtask

    // Matrix fields: all poll codes, sizes and edge modes, threshold end bits
    task automatic t_matrix();
        logic [23:0] w;
        logic [9:0] t;
        for (int i = 0; i < 8; i++)
        begin
            t = 10'(10'h201 + i * 10'h07f);
            w = {7'h00, 2'(i), t, 2'(i + 1), 3'(i)};
            host.write_word(6'h31, w | 24'hfe0000);
            rd_chk(6'h31, w, 1'b1);
            check({7'h0, mat_seen}, w);
            check({23'h0, menab}, {23'h0, w[4:3] != 2'b00});
            check(24'(poll_cyc), 24'(poll_us[i] * CYC_US));
        end
    endtask

    // Unmapped offsets take no write, read zero, and leave neighbours alone
    task automatic t_unmapped();
        host.write_word(6'h2f, 24'h012345);
        host.write_word(6'h2e, 24'hffffff);
        host.write_word(6'h32, 24'hffffff);
        rd_chk(6'h2e, 24'h000000, 1'b0);
        rd_chk(6'h32, 24'h000000, 1'b0);
        rd_chk(6'h2f, 24'h012345, 1'b1);
    endtask

    // Crossing events per edge mode; equal to threshold is not above it
    task automatic t_cross();
        logic f;
        for (int m = 0; m < 4; m++)
        begin
            host.write_word(6'h31, 24'h000000);
            host.write_word(6'h31, {7'h0, 2'(m), 10'd100, 2'b01, 3'h0});
            send(10'd50, f);
            check({23'h0, f}, 24'h000000);
            send(10'd200, f);
            check({23'h0, f}, {23'h0, m[0]});
            send(10'd50, f);
            check({23'h0, f}, {23'h0, m[1]});
            send(10'd100, f);
            check({23'h0, f}, 24'h000000);
            send(10'd101, f);
            check({23'h0, f}, {23'h0, m[0]});
        end
        // No matrix: samples are ignored even with both edges armed
        host.write_word(6'h31, {7'h0, 2'b11, 10'd100, 2'b00, 3'h0});
        send(10'd50, f);
        check({23'h0, f}, 24'h000000);
        send(10'd200, f);
        check({23'h0, f}, 24'h000000);
    endtask

    // Mid-run reset puts every field back to slot zero and no matrix
    task automatic t_rerst();
        host.write_word(6'h2f, 24'h03ffff);
        host.write_word(6'h31, 24'h01ffff);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_chk(6'h2f, 24'h000000, 1'b1);
        rd_chk(6'h31, 24'h000000, 1'b1);
        check({6'h0, map1_seen}, 24'h000000);
        check(24'(poll_cyc), 24'(POLL_US_0 * CYC_US));
    endtask

    // Reset for four cycles, then the scenarios in turn
    initial
    begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        smp_valid = 1'b0;
        smp_value = 10'h000;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_maps();
        t_matrix();
        t_unmapped();
        t_rerst();
        t_cross();
        conclude();
    end
endmodule
